// file: rtl/line_ctrl_cfg.svh
// Offsets, field positions, reset values and timing counts of the line interface control.
// Assumes inclusion by bare name from the design modules.
`ifndef LINE_CTRL_CFG_SVH
`define LINE_CTRL_CFG_SVH

`define LIC_ONE_OFFSET 12'h010
`define LIC_ONE_RESET 8'h00
`define LIC_ONE_WMASK 8'hEF
`define LIC_HOOK_OFFSET 12'h014
`define LIC_BIT_TERM_SQL 7
`define LIC_BIT_ONHOOK_SPEED 6
`define LIC_BIT_AC_TERM 5
`define LIC_BIT_DC_MODE_HI 3
`define LIC_BIT_DC_MODE_LO 2
`define LIC_BIT_RINGER_Z 1
`define LIC_BIT_RING_THR 0
`define LIC_FAST_SAMPLES 1024
`define LIC_SLOW_SAMPLES 4096

`endif

// file: rtl/line_ctrl_pkg.sv
// Types shared by the line interface control register and its testbench.
// Assumes the configuration header sits beside it.
package line_ctrl_pkg;

  typedef enum logic [1:0] {
    DC_LOW_VOLTAGE = 2'h0,
    DC_LOWER_VOLTAGE = 2'h1,
    DC_STANDARD = 2'h2,
    DC_CURRENT_LIMIT = 2'h3
  } dc_mode_type;

  typedef struct packed {
    logic term_off_or_ring_squelch;
    logic onhook_speed_select;
    logic ac_termination_select;
    logic reserved;
    dc_mode_type dc_termination_mode;
    logic ringer_impedance_select;
    logic ring_threshold_select;
  } lic_one_type;

  typedef struct packed {
    logic dc_term_disable;
    logic enhanced_squelch;
    logic ac_complex;
    dc_mode_type dc_mode;
    logic ringer_synth;
    logic ring_thr_high;
    logic low_dc_pin_voltage;
  } line_ctrl_type;

  typedef enum logic [2:0] {
    HOOK_ON = 3'h1,
    HOOK_OFF = 3'h2,
    HOOK_RELEASE = 3'h4
  } hook_state_type;

endpackage

// file: rtl/onhook_release_counter.sv
// Counts sample-rate strobes during an on-hook release.
// Assumes sample_tick is a one-cycle pulse at the line sample rate.
`timescale 1ns/1ps
`include "line_ctrl_cfg.svh"

module onhook_release_counter #(
  parameter int FAST_SAMPLES = `LIC_FAST_SAMPLES,
  parameter int SLOW_SAMPLES = `LIC_SLOW_SAMPLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic slow,
  input wire logic sample_tick,
  output logic done
);
  logic [12:0] count;
  logic [12:0] limit;

  // Length is latched at start so a mid-release write cannot stretch it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= 13'h0000;
      limit <= 13'h0000;
    end else if (start) begin
      count <= 13'h0000;
      limit <= slow ? 13'(SLOW_SAMPLES) : 13'(FAST_SAMPLES);
    end else if (sample_tick && count != limit) begin
      count <= count + 13'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done <= 1'b0;
    end else begin
      done <= !start && sample_tick && (count + 13'h0001 == limit);
    end
  end
endmodule

// file: rtl/line_interface_control.sv
// APB slave for the line interface control register and its decoded line controls.
// Assumes a single pclk domain; hook request and sample tick come from line-side logic.
`timescale 1ns/1ps
`include "line_ctrl_cfg.svh"

// Function
// - Bit 7 means termination off when off-hook, squelch when on-hook.
// - Off-hook with bit 7 set disables dc termination, 800 ohm, low pin voltage (no 800 ohm output here; ac_complex still follows bit 5).
// - On-hook with bit 7 set enables enhanced squelch on ring sense pins.
// - Speed bit picks release counter of 1024 or 4096 sample periods.
// - AC termination bit selects real (0) or complex (1) impedance.
// - Bits 3:2 select low, lower, standard or current limiting dc mode.
// - Ringer bit selects high (0) or synthesized (1) ringer impedance.
// - Ring threshold bit selects 11-22 Vrms (0) or 17-33 Vrms (1).
module line_interface_control #(
  parameter int FAST_SAMPLES = `LIC_FAST_SAMPLES,
  parameter int SLOW_SAMPLES = `LIC_SLOW_SAMPLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic offhook_request,
  input wire logic sample_tick,
  output line_ctrl_pkg::line_ctrl_type line_ctrl,
  output logic offhook,
  output logic releasing
);
  line_ctrl_pkg::lic_one_type ctrl;
  line_ctrl_pkg::hook_state_type hook;
  logic access;
  logic hit_ctrl;
  logic hit_hook;
  logic release_done;
  logic release_start;
  logic is_off;

  // =====================================================================
  // Bus decode
  // One wait state: pready answers the cycle after the access is taken
  assign access = psel && penable && !pready;
  assign hit_ctrl = paddr == `LIC_ONE_OFFSET;
  assign hit_hook = paddr == `LIC_HOOK_OFFSET;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= access;
      pslverr <= access && !hit_ctrl && !hit_hook;
      if (access && !pwrite && hit_ctrl) begin
        prdata <= {24'h000000, ctrl & `LIC_ONE_WMASK};
      end else if (access && !pwrite && hit_hook) begin
        prdata <= {30'h00000000, releasing, offhook};
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end

  // =====================================================================
  // Control register
  // Bit 4 is never stored so readback of reserved is zero by construction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `LIC_ONE_RESET;
    end else if (access && pwrite && hit_ctrl && pstrb[0]) begin
      ctrl <= pwdata[7:0] & `LIC_ONE_WMASK;
    end
  end

  // =====================================================================
  // Hook state and release
  assign is_off = hook != line_ctrl_pkg::HOOK_ON;
  assign release_start = hook == line_ctrl_pkg::HOOK_OFF && !offhook_request;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hook <= line_ctrl_pkg::HOOK_ON;
    end else begin
      unique case (hook)
        line_ctrl_pkg::HOOK_ON: begin
          if (offhook_request) begin
            hook <= line_ctrl_pkg::HOOK_OFF;
          end
        end
        line_ctrl_pkg::HOOK_OFF: begin
          if (!offhook_request) begin
            hook <= line_ctrl_pkg::HOOK_RELEASE;
          end
        end
        line_ctrl_pkg::HOOK_RELEASE: begin
          if (release_done) begin
            hook <= line_ctrl_pkg::HOOK_ON;
          end
        end
        default: begin
          hook <= line_ctrl_pkg::HOOK_ON;
        end
      endcase
    end
  end

  onhook_release_counter #(
    .FAST_SAMPLES(FAST_SAMPLES),
    .SLOW_SAMPLES(SLOW_SAMPLES)
  ) release_count (
    .pclk(pclk),
    .presetn(presetn),
    .start(release_start),
    .slow(ctrl.onhook_speed_select),
    .sample_tick(sample_tick),
    .done(release_done)
  );

  // =====================================================================
  // Decoded line controls, registered so outputs come from flip-flops
  // Release still counts as off-hook, so bit 7 keeps its termination meaning
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_ctrl <= '0;
      offhook <= 1'b0;
      releasing <= 1'b0;
    end else begin
      line_ctrl.dc_term_disable <= is_off && ctrl.term_off_or_ring_squelch;
      line_ctrl.low_dc_pin_voltage <= is_off && ctrl.term_off_or_ring_squelch;
      line_ctrl.enhanced_squelch <= !is_off && ctrl.term_off_or_ring_squelch;
      line_ctrl.ac_complex <= ctrl.ac_termination_select;
      line_ctrl.dc_mode <= ctrl.dc_termination_mode;
      line_ctrl.ringer_synth <= ctrl.ringer_impedance_select;
      line_ctrl.ring_thr_high <= ctrl.ring_threshold_select;
      offhook <= is_off;
      releasing <= hook == line_ctrl_pkg::HOOK_RELEASE;
    end
  end

  // =====================================================================
  // Checks
  reserved_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pready && !pwrite && hit_ctrl) |-> prdata[4] == 1'b0)
    else $error("reserved bit read as one");

  readback_a: assert property (@(posedge pclk) disable iff (!presetn)
    (access && !pwrite && hit_ctrl) |=> prdata[7:0] == $past(8'(ctrl)))
    else $error("readback differs from stored value");

  write_lands_a: assert property (@(posedge pclk) disable iff (!presetn)
    (access && pwrite && hit_ctrl && pstrb[0]) |=> 8'(ctrl) == ($past(pwdata[7:0]) & 8'hEF))
    else $error("write did not land");

  term_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    (is_off && ctrl.term_off_or_ring_squelch)
    |=> line_ctrl.dc_term_disable && line_ctrl.low_dc_pin_voltage)
    else $error("dc termination not disabled");

  squelch_on_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!is_off && ctrl.term_off_or_ring_squelch)
    |=> line_ctrl.enhanced_squelch && !line_ctrl.dc_term_disable)
    else $error("squelch not enabled on-hook");

  bit7_exclusive_a: assert property (@(posedge pclk) disable iff (!presetn)
    !(line_ctrl.enhanced_squelch && line_ctrl.dc_term_disable))
    else $error("bit 7 meanings overlap");

  ac_term_a: assert property (@(posedge pclk) disable iff (!presetn)
    line_ctrl.ac_complex == $past(ctrl.ac_termination_select))
    else $error("ac termination mismatch");

  dc_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
    line_ctrl.dc_mode == $past(ctrl.dc_termination_mode))
    else $error("dc mode mismatch");

  ringer_thr_a: assert property (@(posedge pclk) disable iff (!presetn)
    line_ctrl.ringer_synth == $past(ctrl.ringer_impedance_select)
    && line_ctrl.ring_thr_high == $past(ctrl.ring_threshold_select))
    else $error("ringer setting mismatch");

  release_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (release_start && sample_tick) |=> (hook == line_ctrl_pkg::HOOK_RELEASE) [*8])
    else $error("release ended too early");
endmodule

// file: dv/line_side_model.sv
// Line-side partner: hook control and the sample-rate strobe.
// Assumes the sample period equals one pclk cycle, so counts stay short.
`timescale 1ns/1ps

module line_side_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic hook_cmd,
  output logic offhook_request,
  output logic sample_tick
);
  // ==========================================
  // Hook request and sample strobe
  // A strobe every cycle is the fastest rate the counter must accept
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      offhook_request <= 1'b0;
      sample_tick <= 1'b0;
    end else begin
      offhook_request <= hook_cmd;
      sample_tick <= 1'b1;
    end
  end
endmodule

// file: dv/line_interface_control_tb_top.sv
// Self-checking bench for the line interface control register.
// Assumes one pclk domain and the line-side model as hook partner.
`timescale 1ns/1ps

module line_interface_control_tb_top;
  logic pclk, presetn, psel, penable, pwrite, hook_cmd;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  logic [3:0] pstrb;
  logic [31:0] prdata;
  logic pready, pslverr, offhook_request, sample_tick, offhook, releasing, er;
  line_ctrl_pkg::line_ctrl_type line_ctrl;
  int errors, checks;
  logic [7:0] rows [5] = '{8'hFF, 8'h00, 8'hA4, 8'h49, 8'h0E};

  line_interface_control #(.FAST_SAMPLES(10), .SLOW_SAMPLES(20)) i_line_interface_control (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .offhook_request(offhook_request), .sample_tick(sample_tick),
    .line_ctrl(line_ctrl), .offhook(offhook), .releasing(releasing));
  line_side_model i_line_side_model (.pclk(pclk), .presetn(presetn), .hook_cmd(hook_cmd),
    .offhook_request(offhook_request), .sample_tick(sample_tick));

  // ==========================================
  // Tasks
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Waits for pready with no assumed latency; the watchdog ends a hang
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  task automatic end_sim;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ==========================================
  // Clock, watchdog and tests
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  initial begin
    #400000;
    errors++;
    end_sim();
  end

  initial begin
    {psel, penable, pwrite, hook_cmd} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'hF;
    presetn = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h010, 32'h0, 4'hF);
    chk("reset value", 32'h0, rd);
    chk("reset ctrl", 32'h0, 32'(line_ctrl));
    $display("test reset done");
    foreach (rows[i]) begin
      apb(1'b1, 12'h010, {24'h0, rows[i]}, 4'hF);
      apb(1'b0, 12'h010, 32'h0, 4'hF);
      chk("readback", {24'h0, rows[i] & 8'hEF}, rd);
      chk("onhook ctrl", {1'b0, rows[i][7], rows[i][5], rows[i][3:2], rows[i][1:0], 1'b0},
          32'(line_ctrl));
    end
    $display("test table done");
    apb(1'b1, 12'h010, 32'hFF, 4'h0);
    apb(1'b0, 12'h3FC, 32'h0, 4'hF);
    chk("unmapped error", 32'h1, {31'h0, er});
    apb(1'b0, 12'h010, 32'h0, 4'hF);
    chk("strobe ignored", 32'h0E, rd);
    $display("test refusals done");
    apb(1'b1, 12'h010, 32'hC0, 4'hF);
    hook_cmd <= 1'b1;
    wait_cyc(4);
    chk("offhook ctrl", 32'h81, 32'(line_ctrl));
    apb(1'b0, 12'h014, 32'h0, 4'hF);
    chk("status offhook", 32'h1, rd);
    @(posedge pclk);
    hook_cmd <= 1'b0;
    wait_cyc(15);
    chk("slow releasing", 32'h1, {31'h0, releasing});
    wait_cyc(12);
    chk("slow done", 32'h0, {31'h0, offhook});
    // Host arms squelch once the line is back on-hook, then clears it again
    apb(1'b1, 12'h010, 32'h80, 4'hF);
    wait_cyc(1);
    chk("squelch on", 32'h40, 32'(line_ctrl));
    apb(1'b1, 12'h010, 32'h00, 4'hF);
    hook_cmd <= 1'b1;
    wait_cyc(4);
    chk("squelch cleared", 32'h0, 32'(line_ctrl));
    @(posedge pclk);
    hook_cmd <= 1'b0;
    wait_cyc(15);
    chk("fast done", 32'h0, {31'h0, releasing});
    $display("test hook done");
    // Reset in mid-run must clear a written setting and the hook state
    apb(1'b1, 12'h010, 32'h2D, 4'hF);
    presetn <= 1'b0;
    wait_cyc(2);
    chk("reset ctrl mid", 32'h0, 32'(line_ctrl));
    chk("reset hook mid", 32'h0, {30'h0, releasing, offhook});
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h010, 32'h0, 4'hF);
    chk("reset value mid", 32'h0, rd);
    $display("test mid reset done");
    end_sim();
  end
endmodule
